/* pkg/nand_guard_pkg.sv */
/*
 * Constants for the NAND write-protect and block-care host sequencer.
 * Assumes a 125 MHz mclk and an asynchronous NAND device on plain pins.
 */
// Functional notes
// - host never lowers protect after confirm
// - host holds protect low during power ramps; host holds it high in program/erase S_WAIT and S_STAT
// - marker byte not erased means bad block
// - scan markers before any erase
// - failed program/erase retires the block
// - host ECC corrects four bits per 528 bytes; the host has no ECC datapath, only the constants
// - busy budgets 2000 us program, 10 ms erase
// - each page programmed once between erases; host tracks only the last programmed block and page
package nand_guard_pkg;
    // ==========================================================
    // commands and status fields
    localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
    localparam logic [7:0] CMD_PROG_CONF   = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
    localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
    localparam logic [7:0] CMD_READ_CONF   = 8'h30;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;
    localparam int PROTECT_STATE_POS = 7;
    localparam int IDLE_POS          = 6;
    localparam int FAIL_POS          = 0;
    // ==========================================================
    // geometry
    localparam int BLK_W       = 12;
    localparam int PAGE_W      = 7;
    localparam int COL_W       = 13;
    localparam logic [PAGE_W-1:0] LAST_PAGE   = 7'h7F;
    localparam logic [COL_W-1:0]  SPARE_COL   = 13'h1000;
    localparam int ECC_BITS    = 4;
    localparam int ECC_BYTES   = 528;
    localparam int PARTIAL_PROGRAM_LIMIT = 1;
    // ==========================================================
    // timing
    localparam int CLK_NS       = 8;
    localparam int PIN_STEP_NS  = 40;
    localparam int PIN_STEP_CYC = (PIN_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOCK_LOW_TO_WE_HIGH_NS  = 100;
    localparam int LOCK_LOW_TO_WE_HIGH_CYC = (LOCK_LOW_TO_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_MAX_US  = 2000;
    localparam int ERASE_MAX_MS = 10;
    localparam int PROG_MAX_CYC  = PROG_MAX_US * 1000 / CLK_NS;
    localparam int ERASE_MAX_CYC = ERASE_MAX_MS * 1000000 / CLK_NS;
    localparam int TMR_W = 24;
    // ==========================================================
    // host operations and results
    typedef enum logic [1:0] {OP_SCAN, OP_PROGRAM, OP_ERASE, OP_NONE} op_t;
    typedef enum logic [2:0] {RES_OK, RES_BAD, RES_FAIL, RES_HUNG, RES_REFUSED,
                              RES_UNSCANNED, RES_REPROG} res_t;
endpackage

/* rtl/block_table.sv */
/*
 * Bad-block and scanned-flag memory for the host sequencer.
 * Assumes one write per cycle; read data comes out one cycle later.
 */
`timescale 1ns/1ps
module block_table
    import nand_guard_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic [BLK_W-1:0]  rdAddr,
    output logic      [1:0]        rdData,
    input  wire logic              wrEn,
    input  wire logic [BLK_W-1:0]  wrAddr,
    input  wire logic [1:0]        wrData
);
    // ==========================================================
    // bit1 = block known bad, bit0 = block scanned
    logic [1:0]            mem [0:(1<<BLK_W)-1];
    logic [(1<<BLK_W)-1:0] seen_ff, nxt_seen;
    logic [1:0]            rdData_ff;

    // bad flag storage has no reset; it is only trusted once seen is set
    always_ff @(posedge mclk)
    begin
        if (wrEn)
            mem[wrAddr] <= wrData;
    end

    // scanned flags are reset: power-up junk would let an unscanned block through
    always_comb
    begin
        nxt_seen = seen_ff;
        if (wrEn)
            nxt_seen[wrAddr] = wrData[0];
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seen_ff   <= '0;
            rdData_ff <= 2'h0;
        end
        else
        begin
            seen_ff   <= nxt_seen;
            rdData_ff <= {mem[rdAddr][1], seen_ff[rdAddr]};
        end
    end

    assign rdData = rdData_ff;
endmodule

/* rtl/nand_guard_host.sv */
/*
 * Host sequencer driving a NAND device: protect pin, bad-block scan,
 * program and erase with busy budgets, failure retire.
 * Assumes device pins sampled synchronously to mclk; no ECC datapath here.
 */
`timescale 1ns/1ps
module nand_guard_host
    import nand_guard_pkg::*;
#(
    parameter int PROG_LIMIT  = PROG_MAX_CYC,
    parameter int ERASE_LIMIT = ERASE_MAX_CYC
)
(
    input  wire logic                        mclk,
    input  wire logic                        arst_n,
    input  wire logic                        powerGood,
    input  wire logic                        reqValid,
    output logic                             reqReady,
    input  wire nand_guard_pkg::op_t         reqOp,
    input  wire logic [nand_guard_pkg::BLK_W-1:0]  reqBlock,
    input  wire logic [nand_guard_pkg::PAGE_W-1:0] reqPage,
    input  wire logic [7:0]                  reqData,
    output logic                             doneValid,
    output nand_guard_pkg::res_t             doneRes,
    output logic [7:0]                       doneStatus,
    output logic                             ceN,
    output logic                             cle,
    output logic                             ale,
    output logic                             weN,
    output logic                             reN,
    output logic                             wpN,
    output logic [7:0]                       ioOut,
    output logic                             ioOe,
    input  wire logic [7:0]                  ioIn,
    input  wire logic                        ready_busy_n
);
    import nand_guard_pkg::*;

    typedef enum {S_IDLE, S_LOOK, S_CHECK, S_CMD, S_WAIT, S_STAT, S_RDBYTE, S_DONE} st_t;
    typedef enum {K_CMD, K_ADR, K_DAT, K_RD} kind_t;

    // ==========================================================
    // one pin cycle: returns 1 when the step counter has run out
    function automatic logic stepDone(input logic [3:0] c);
        return c == 4'(PIN_STEP_CYC - 1);
    endfunction

    // budget for the busy wait of the running operation
    function automatic logic [TMR_W-1:0] budget(input op_t o);
        return (o == OP_ERASE) ? TMR_W'(ERASE_LIMIT) :
               (o == OP_PROGRAM) ? TMR_W'(PROG_LIMIT) : TMR_W'(PROG_LIMIT);
    endfunction

    st_t              st_ff, nxt_st;
    op_t              op_ff, nxt_op;
    res_t             res_ff, nxt_res;
    logic [BLK_W-1:0] blk_ff, nxt_blk;
    logic [PAGE_W-1:0] pg_ff, nxt_pg;
    logic [7:0]       dat_ff, nxt_dat;
    logic [3:0]       seq_ff, nxt_seq;
    logic [3:0]       step_ff, nxt_step;
    logic [TMR_W-1:0] tmr_ff, nxt_tmr;
    logic [7:0]       stat_ff, nxt_stat;
    logic             wpN_ff, nxt_wpN;
    logic [3:0]       wpCnt_ff, nxt_wpCnt;
    logic             done_ff, nxt_done;
    logic [7:0]       byteOut;
    kind_t            kind;
    logic             lastSeq;
    logic [1:0]       tblRd;
    logic             tblWr;
    logic [1:0]       tblWrData;
    logic [PAGE_W-1:0] usedPage_ff, nxt_usedPage;
    logic             usedValid_ff, nxt_usedValid;
    logic [BLK_W-1:0] usedBlk_ff, nxt_usedBlk;

    block_table u_table (
        .mclk   (mclk),
        .arst_n (arst_n),
        .rdAddr (reqValid && reqReady ? reqBlock : blk_ff),
        .rdData (tblRd),
        .wrEn   (tblWr),
        .wrAddr (blk_ff),
        .wrData (tblWrData)
    );

    // ==========================================================
    // byte sequence per operation: index selects command/address/data
    always_comb
    begin
        kind    = K_CMD;
        byteOut = 8'h00;
        lastSeq = 1'b0;
        unique case (op_ff)
            OP_SCAN:     // read marker byte of last page spare area
            begin
                unique case (seq_ff)
                    4'd0: byteOut = CMD_READ_SETUP;
                    4'd1: begin kind = K_ADR; byteOut = SPARE_COL[7:0]; end
                    4'd2: begin kind = K_ADR; byteOut = {3'h0, SPARE_COL[12:8]}; end
                    4'd3: begin kind = K_ADR; byteOut = {LAST_PAGE, blk_ff[0]}; end
                    4'd4: begin kind = K_ADR; byteOut = blk_ff[8:1]; end
                    4'd5: begin kind = K_ADR; byteOut = {5'h0, blk_ff[11:9]}; end
                    default: begin byteOut = CMD_READ_CONF; lastSeq = 1'b1; end
                endcase
            end
            OP_PROGRAM:
            begin
                unique case (seq_ff)
                    4'd0: byteOut = CMD_PROG_SETUP;
                    4'd1: begin kind = K_ADR; byteOut = 8'h00; end
                    4'd2: begin kind = K_ADR; byteOut = 8'h00; end
                    4'd3: begin kind = K_ADR; byteOut = {pg_ff, blk_ff[0]}; end
                    4'd4: begin kind = K_ADR; byteOut = blk_ff[8:1]; end
                    4'd5: begin kind = K_ADR; byteOut = {5'h0, blk_ff[11:9]}; end
                    4'd6: begin kind = K_DAT; byteOut = dat_ff; end
                    default: begin byteOut = CMD_PROG_CONF; lastSeq = 1'b1; end
                endcase
            end
            default:
            begin
                unique case (seq_ff)
                    4'd0: byteOut = CMD_ERASE_SETUP;
                    4'd1: begin kind = K_ADR; byteOut = {7'h00, blk_ff[0]}; end
                    4'd2: begin kind = K_ADR; byteOut = blk_ff[8:1]; end
                    4'd3: begin kind = K_ADR; byteOut = {5'h0, blk_ff[11:9]}; end
                    default: begin byteOut = CMD_ERASE_CONF; lastSeq = 1'b1; end
                endcase
            end
        endcase
    end

    // ==========================================================
    // main sequencer next state
    always_comb
    begin
        nxt_st = st_ff; nxt_op = op_ff; nxt_res = res_ff; nxt_blk = blk_ff;
        nxt_pg = pg_ff; nxt_dat = dat_ff; nxt_seq = seq_ff; nxt_step = step_ff;
        nxt_tmr = tmr_ff; nxt_stat = stat_ff; nxt_done = 1'b0;
        nxt_usedPage = usedPage_ff; nxt_usedValid = usedValid_ff;
        nxt_usedBlk = usedBlk_ff;
        tblWr = 1'b0; tblWrData = 2'h0;
        // read data is only valid while the strobe is low; the device bus shows the inverse of the byte after
        if (!reN)
            nxt_stat = ioIn;
        unique case (st_ff)
            S_IDLE:
                if (reqValid && powerGood && wpCnt_ff == 4'(LOCK_LOW_TO_WE_HIGH_CYC))
                begin
                    nxt_op = reqOp; nxt_blk = reqBlock; nxt_pg = reqPage;
                    nxt_dat = reqData; nxt_seq = 4'd0; nxt_step = 4'd0;
                    nxt_st = S_LOOK;
                end
            S_LOOK: nxt_st = S_CHECK;   // table read latency
            S_CHECK:
                if (op_ff != OP_SCAN && !tblRd[0])
                begin nxt_res = RES_UNSCANNED; nxt_st = S_DONE; end
                else if (op_ff != OP_SCAN && tblRd[1])
                begin nxt_res = RES_BAD; nxt_st = S_DONE; end
                else if (op_ff == OP_PROGRAM && usedValid_ff && usedBlk_ff == blk_ff
                         && usedPage_ff >= pg_ff)
                begin nxt_res = RES_REPROG; nxt_st = S_DONE; end
                else
                    nxt_st = S_CMD;
            S_CMD:
            begin
                nxt_step = step_ff + 4'd1;
                if (stepDone(step_ff))
                begin
                    nxt_step = 4'd0;
                    nxt_seq  = seq_ff + 4'd1;
                    if (lastSeq)
                    begin
                        nxt_tmr = budget(op_ff);
                        nxt_st  = S_WAIT;
                    end
                end
            end
            S_WAIT:
            begin
                nxt_tmr = tmr_ff - TMR_W'(1);
                if (tmr_ff == '0)
                begin nxt_res = RES_HUNG; nxt_st = S_DONE; end
                else if (ready_busy_n && tmr_ff < budget(op_ff) - TMR_W'(4))
                begin
                    nxt_step = 4'd0; nxt_seq = 4'd0;
                    nxt_st = (op_ff == OP_SCAN) ? S_RDBYTE : S_STAT;
                end
            end
            S_STAT:   // status command then one read
            begin
                nxt_step = step_ff + 4'd1;
                if (stepDone(step_ff))
                begin
                    nxt_step = 4'd0;
                    nxt_seq = seq_ff + 4'd1;
                    if (seq_ff == 4'd1)
                    begin
                        if (!stat_ff[PROTECT_STATE_POS])
                            nxt_res = RES_REFUSED;
                        else if (stat_ff[FAIL_POS])
                        begin
                            nxt_res = RES_FAIL;
                            tblWr = 1'b1; tblWrData = 2'b11;
                        end
                        else
                            nxt_res = RES_OK;
                        if (op_ff == OP_ERASE && !stat_ff[FAIL_POS])
                            nxt_usedValid = 1'b0;
                        if (op_ff == OP_PROGRAM)
                        begin
                            nxt_usedValid = 1'b1; nxt_usedBlk = blk_ff;
                            nxt_usedPage = pg_ff;
                        end
                        nxt_st = S_DONE;
                    end
                end
            end
            S_RDBYTE:
            begin
                nxt_step = step_ff + 4'd1;
                if (stepDone(step_ff))
                begin
                    tblWr = 1'b1;
                    tblWrData = {stat_ff != ERASED_BYTE, 1'b1};
                    nxt_res = (stat_ff != ERASED_BYTE) ? RES_BAD : RES_OK;
                    nxt_st = S_DONE;
                end
            end
            default:
            begin
                nxt_done = 1'b1;
                nxt_st = S_IDLE;
            end
        endcase
    end

    // ==========================================================
    // protect pin: low while supply unsafe except in program/erase S_WAIT/S_STAT, high a margin before any cycle
    always_comb
    begin
        nxt_wpN = powerGood;
        nxt_wpCnt = wpCnt_ff;
        if (!powerGood)
            nxt_wpCnt = 4'd0;
        else if (wpCnt_ff != 4'(LOCK_LOW_TO_WE_HIGH_CYC))
            nxt_wpCnt = wpCnt_ff + 4'd1;
        // hold protect high in S_WAIT and S_STAT of program/erase once the confirm has gone out
        if ((st_ff == S_WAIT || st_ff == S_STAT) && op_ff != OP_SCAN)
            nxt_wpN = 1'b1;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= S_IDLE; op_ff <= OP_NONE; res_ff <= RES_OK;
            blk_ff <= '0; pg_ff <= '0; dat_ff <= 8'h00; seq_ff <= 4'd0;
            step_ff <= 4'd0; tmr_ff <= '0; stat_ff <= 8'h00;
            wpN_ff <= 1'b0; wpCnt_ff <= 4'd0; done_ff <= 1'b0;
            usedPage_ff <= '0; usedValid_ff <= 1'b0; usedBlk_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st; op_ff <= nxt_op; res_ff <= nxt_res;
            blk_ff <= nxt_blk; pg_ff <= nxt_pg; dat_ff <= nxt_dat;
            seq_ff <= nxt_seq; step_ff <= nxt_step; tmr_ff <= nxt_tmr;
            stat_ff <= nxt_stat; wpN_ff <= nxt_wpN; wpCnt_ff <= nxt_wpCnt;
            done_ff <= nxt_done; usedPage_ff <= nxt_usedPage;
            usedValid_ff <= nxt_usedValid; usedBlk_ff <= nxt_usedBlk;
        end
    end

    // ==========================================================
    // pin drive: we/re low for the first 2 of the 5 cycles of each step
    logic lowHalf;
    assign lowHalf    = step_ff < 4'(PIN_STEP_CYC / 2);
    assign ceN        = !(st_ff == S_CMD || st_ff == S_STAT || st_ff == S_RDBYTE);
    assign cle        = (st_ff == S_CMD && kind == K_CMD) || (st_ff == S_STAT && seq_ff == 4'd0);
    assign ale        = st_ff == S_CMD && kind == K_ADR;
    assign weN        = !((st_ff == S_CMD || (st_ff == S_STAT && seq_ff == 4'd0)) && lowHalf);
    assign reN        = !(((st_ff == S_STAT && seq_ff == 4'd1) || st_ff == S_RDBYTE) && lowHalf);
    assign ioOe       = st_ff == S_CMD || (st_ff == S_STAT && seq_ff == 4'd0);
    assign ioOut      = (st_ff == S_STAT) ? CMD_STATUS : byteOut;
    assign wpN        = wpN_ff;
    assign reqReady   = st_ff == S_IDLE && powerGood
                        && wpCnt_ff == 4'(LOCK_LOW_TO_WE_HIGH_CYC);
    assign doneValid  = done_ff;
    assign doneRes    = res_ff;
    assign doneStatus = stat_ff;

    // ==========================================================
    // checks
    a_wp_held_busy: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_ff == S_WAIT && op_ff != OP_SCAN) |-> wpN)
        else $error("protect dropped after confirm");
    a_wp_setup_gap: assert property (@(posedge mclk) disable iff (!arst_n)
        $fell(weN) |-> wpN && $past(wpN, LOCK_LOW_TO_WE_HIGH_CYC))
        else $error("write strobe too soon after protect rise");
    a_lock_power: assert property (@(posedge mclk) disable iff (!arst_n)
        !powerGood |=> !wpN)
        else $error("protect high with bad supply");
    a_hang_budget: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_ff == S_WAIT && tmr_ff == '0) |=> st_ff == S_DONE && res_ff == RES_HUNG)
        else $error("hung operation not reported");
    a_bad_mark: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_ff == S_RDBYTE && stepDone(step_ff) && stat_ff != ERASED_BYTE)
        |=> res_ff == RES_BAD ##1 doneValid)
        else $error("marker not flagged bad");
    a_fail_retire: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_ff == S_STAT && seq_ff == 4'd1 && stepDone(step_ff)
         && stat_ff[PROTECT_STATE_POS] && stat_ff[FAIL_POS]) |-> tblWr && tblWrData == 2'b11)
        else $error("failed block not retired");
    a_refuse_prot: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_ff == S_STAT && seq_ff == 4'd1 && stepDone(step_ff)
         && !stat_ff[PROTECT_STATE_POS]) |=> res_ff == RES_REFUSED)
        else $error("protected status not reported");
    a_scan_first: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_ff == S_CHECK && op_ff == OP_ERASE && !tblRd[0]) |=> res_ff == RES_UNSCANNED)
        else $error("erase of unscanned block");
endmodule

/* test/nand_dev_model.sv */
/*
 * Behavioural NAND device facing the host sequencer.
 * Assumes host pins of nand_guard_host; no clock, reacts to weN and reN edges.
 */
`timescale 1ns/1ps
module nand_dev_model
    import nand_guard_pkg::*;
#(
    parameter logic [BLK_W-1:0] BAD_BLK  = 12'h00C,
    parameter logic [BLK_W-1:0] FAIL_BLK = 12'h00A
)
(
    input  wire logic       powerGood,
    input  wire logic       slowMode,
    input  wire logic       ceN,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       weN,
    input  wire logic       reN,
    input  wire logic       wpN,
    input  wire logic [7:0] ioOut,
    output logic      [7:0] ioIn,
    output logic            ready_busy_n
);
    logic [7:0] mem [bit [31:0]];
    logic [7:0] adr [0:4];
    logic [7:0] cmd = 8'h00;
    logic [7:0] pend = 8'h00;
    logic [7:0] dout = 8'h00;
    logic       fail = 1'b0;
    logic       statMode = 1'b0;
    logic       isErase = 1'b0;
    int         nAdr = 0;
    int         t;
    event       startEv;
    initial ready_busy_n = 1'b1;
    // ==========================================================
    // array access
    function automatic logic [31:0] key_of();
        int b;
        b = isErase ? 0 : 2;
        return {adr[b+2][2:0], adr[b+1], adr[b][0], adr[b][7:1], adr[1][4:0], adr[0]};
    endfunction
    function automatic logic [7:0] rd(input logic [31:0] k);
        if (mem.exists(k))
            return mem[k];
        if (k[31:20] == BAD_BLK && k[19:13] == LAST_PAGE && k[12:0] == SPARE_COL)
            return 8'h00;
        return ERASED_BYTE;
    endfunction
    // ==========================================================
    // bus cycles: latch on weN rising, whole device dead below lockout
    always @(posedge weN)
    begin
        if (!ceN && powerGood && cle)
        begin
            statMode = (ioOut == CMD_STATUS);
            if (ioOut == CMD_PROG_SETUP || ioOut == CMD_ERASE_SETUP || ioOut == CMD_READ_SETUP)
            begin
                isErase = (ioOut == CMD_ERASE_SETUP);
                nAdr = 0;
            end
            // protected device ignores confirm and stays ready
            if (ioOut == CMD_READ_CONF || (wpN && (ioOut == CMD_PROG_CONF ||
                ioOut == CMD_ERASE_CONF)))
            begin
                cmd = ioOut;
                -> startEv;
            end
        end
        else if (!ceN && powerGood && ale && nAdr < 5)
        begin
            adr[nAdr] = ioOut;
            nAdr++;
        end
        else if (!ceN && powerGood && !ale)
            pend = ioOut;
    end
    // busy phase; a protect drop aborts, runs the internal reset, then ready
    always @(startEv)
    begin
        ready_busy_n = 1'b0;
        for (t = 0; t < (cmd == CMD_READ_CONF ? 200 : cmd == CMD_ERASE_CONF ? 800 :
             slowMode ? 4000 : 400) && (wpN || cmd == CMD_READ_CONF); t += 8)
            #8;
        if (!wpN && cmd != CMD_READ_CONF)
            #(LOCK_LOW_TO_WE_HIGH_NS);
        else if (cmd != CMD_READ_CONF && key_of() >> 20 == FAIL_BLK)
            fail = 1'b1;
        else if (cmd != CMD_READ_CONF)
        begin
            fail = 1'b0;
            if (isErase)
                for (t = 0; t < 128; t++)
                    mem.delete((key_of() & 32'hFFF0_0000) | {12'h000, t[6:0], 13'h0000});
            else
                mem[key_of()] = pend;
        end
        ready_busy_n = 1'b1;
    end
    // read cycles; released bus shows the inverse of the last byte
    always @(negedge reN)
        if (!ceN && powerGood)
            dout = statMode ? {wpN, ready_busy_n, ready_busy_n, 4'h0, fail}
                            : rd(key_of());
    assign ioIn = (!reN && !ceN && powerGood) ? dout : ~dout;
endmodule

/* test/tb_top.sv */
/*
 * Self-checking bench for nand_guard_host against a behavioural device.
 * Assumes short busy budgets via parameters and the device model beside it.
 */
`timescale 1ns/1ps
module tb_top;
    import nand_guard_pkg::*;
    localparam logic [BLK_W-1:0] BAD = 12'h00C;
    localparam logic [BLK_W-1:0] BRK = 12'h00A;
    logic mclk = 1'b0, arst_n = 1'b0, powerGood = 1'b1, reqValid = 1'b0, slowMode = 1'b0;
    logic reqReady, doneValid, ceN, cle, ale, weN, reN, wpN, ioOe, ready_busy_n;
    logic [BLK_W-1:0]  reqBlock = 12'h000;
    logic [PAGE_W-1:0] reqPage = 7'h00;
    logic [7:0]        reqData = 8'h00, doneStatus, ioOut, ioIn;
    op_t               reqOp = OP_NONE;
    res_t              doneRes;
    int                mismatches = 0, n_tests = 0, n;
    nand_guard_host #(.PROG_LIMIT(200), .ERASE_LIMIT(400)) dut (.mclk(mclk), .arst_n(arst_n),
        .powerGood(powerGood), .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
        .reqBlock(reqBlock), .reqPage(reqPage), .reqData(reqData), .doneValid(doneValid),
        .doneRes(doneRes), .doneStatus(doneStatus), .ceN(ceN), .cle(cle), .ale(ale),
        .weN(weN), .reN(reN), .wpN(wpN), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn),
        .ready_busy_n(ready_busy_n));
    nand_dev_model #(.BAD_BLK(BAD), .FAIL_BLK(BRK)) model (.powerGood(powerGood),
        .slowMode(slowMode), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN), .reN(reN),
        .wpN(wpN), .ioOut(ioOut), .ioIn(ioIn), .ready_busy_n(ready_busy_n));
    always #4 mclk = ~mclk;
    // ==========================================================
    // protect must stay high while the device is busy; ioOe must be low while reN is low
    always @(negedge mclk)
    begin
        if (arst_n && ready_busy_n === 1'b0 && wpN !== 1'b1)
        begin
            mismatches++;
            $display("CHECK FAILED wpN expected 1 seen %b", wpN);
        end
        if (arst_n && reN === 1'b0 && ioOe !== 1'b0)
        begin
            mismatches++;
            $display("CHECK FAILED ioOe expected 0 seen %b", ioOe);
        end
    end
    task automatic test_done();
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_ready(input string what);
        for (n = 0; reqReady !== 1'b1 || ready_busy_n !== 1'b1; n++)
        begin
            if (n > 5000)
            begin
                chk(what, 8'h01, 8'h00);
                test_done();
            end
            @(negedge mclk);
        end
    endtask
    // one request, held until the edge that takes it, then wait for done
    task automatic do_op(input op_t op, input logic [BLK_W-1:0] b, input logic [PAGE_W-1:0] p,
                         input logic [7:0] d, input res_t exp, input string what);
        wait_ready("reqReady");
        reqOp = op;
        reqBlock = b;
        reqPage = p;
        reqData = d;
        reqValid = 1'b1;
        @(negedge mclk);
        reqValid = 1'b0;
        for (n = 0; doneValid !== 1'b1; n++)
        begin
            if (n > 5000)
            begin
                chk(what, 8'h01, 8'h00);
                test_done();
            end
            @(negedge mclk);
        end
        chk(what, {5'h00, exp}, {5'h00, doneRes});
    endtask
    // ==========================================================
    // scenarios
    task automatic s_scan();
        do_op(OP_PROGRAM, 12'h005, 7'h00, 8'h11, RES_UNSCANNED, "unscanned");
        do_op(OP_ERASE, 12'h006, 7'h00, 8'h00, RES_UNSCANNED, "erase unscanned");
        do_op(OP_SCAN, 12'h005, 7'h00, 8'h00, RES_OK, "scan good");
        chk("good marker", ERASED_BYTE, doneStatus);
        do_op(OP_SCAN, BAD, 7'h00, 8'h00, RES_BAD, "scan bad");
        chk("bad marker", 8'h00, doneStatus);
        do_op(OP_ERASE, BAD, 7'h00, 8'h00, RES_BAD, "erase bad");
        chk("marker kept", 8'h00, model.rd({BAD, LAST_PAGE, SPARE_COL}));
    endtask
    task automatic s_program();
        do_op(OP_PROGRAM, 12'h005, 7'h03, 8'hA5, RES_OK, "program");
        chk("status bits", 8'h06, {5'h00, doneStatus[7], doneStatus[6], doneStatus[0]});
        chk("array", 8'hA5, model.rd({12'h005, 7'h03, 13'h0000}));
        do_op(OP_PROGRAM, 12'h005, 7'h03, 8'h5A, RES_REPROG, "same page");
        do_op(OP_PROGRAM, 12'h005, 7'h02, 8'h5A, RES_REPROG, "lower page");
        do_op(OP_PROGRAM, 12'h005, 7'h04, 8'h3C, RES_OK, "next page");
    endtask
    task automatic s_erase();
        do_op(OP_ERASE, 12'h005, 7'h00, 8'h00, RES_OK, "erase");
        chk("erased", ERASED_BYTE, model.rd({12'h005, 7'h04, 13'h0000}));
        do_op(OP_PROGRAM, 12'h005, 7'h03, 8'h66, RES_OK, "after erase");
    endtask
    task automatic s_fail();
        do_op(OP_SCAN, BRK, 7'h00, 8'h00, RES_OK, "scan weak");
        do_op(OP_PROGRAM, BRK, 7'h00, 8'h77, RES_FAIL, "program fail");
        chk("fail bit", 8'h01, {7'h00, doneStatus[0]});
        do_op(OP_PROGRAM, BRK, 7'h01, 8'h77, RES_BAD, "retired");
    endtask
    task automatic s_hung();
        do_op(OP_SCAN, 12'h007, 7'h00, 8'h00, RES_OK, "scan slow");
        slowMode = 1'b1;
        do_op(OP_PROGRAM, 12'h007, 7'h00, 8'h01, RES_HUNG, "hung");
        wait_ready("device idle");
        slowMode = 1'b0;
    endtask
    task automatic s_power();
        powerGood = 1'b0;
        repeat (3) @(negedge mclk);
        chk("wpN low", 8'h00, {7'h00, wpN});
        chk("ready low", 8'h00, {7'h00, reqReady});
        powerGood = 1'b1;
        for (n = 0; reqReady !== 1'b1 && n < 100; n++)
            @(negedge mclk);
        if (n == 100)
        begin
            chk("ready back", 8'h01, 8'h00);
            test_done();
        end
        chk("wpN high", 8'h01, {7'h00, wpN});
        chk("settle", 8'h01, {7'h00, n >= LOCK_LOW_TO_WE_HIGH_CYC});
        do_op(OP_SCAN, 12'h009, 7'h00, 8'h00, RES_OK, "after power");
    endtask
    initial
    begin
        repeat (6) @(negedge mclk);
        arst_n = 1'b1;
        s_scan();
        s_program();
        s_erase();
        s_fail();
        s_hung();
        s_power();
        test_done();
    end
endmodule
